// file: link_partner.sv
// Far-side model: transmit engine completing pause frames and back pressure.
// Assumes go levels from the MAC on the same clock; done is a one-cycle pulse.
`timescale 1ns/100ps
`default_nettype none
module link_partner (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic pause_tx_go,
    input  wire logic backp_tx_go,
    input  wire logic slow,
    output logic      pause_done,
    output logic      backp_done
);
    // ------------------------------------------------------------
    // Sequence length counter
    // ------------------------------------------------------------
    logic [5:0] cnt_ff;
    wire logic [5:0] lim = slow ? 6'h14 : 6'h02;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) cnt_ff <= 6'h00;
        else if (pause_tx_go || backp_tx_go) cnt_ff <= cnt_ff + 6'h01;
        else cnt_ff <= 6'h00;
    end
    assign pause_done = pause_tx_go && (cnt_ff == lim);
    assign backp_done = backp_tx_go && (cnt_ff == lim);
endmodule
`default_nettype wire

// file: mac_flow_tag_pkg.sv
// Package for the flow-busy, tag-identifier and wake-filter slice.
// Assumes a single 100 MHz clock domain and a plain strobe register port.
`default_nettype none
package mac_flow_tag_pkg;

    // ------------------------------------------------------------------
    // Register indices and address width
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] IDX_FIRST_TAG  = 8'h09;
    localparam logic [ADDR_W-1:0] IDX_SECOND_TAG = 8'h0A;
    localparam logic [ADDR_W-1:0] IDX_WAKE_LOAD  = 8'h0B;
    localparam logic [ADDR_W-1:0] IDX_FLOW_STAT  = 8'h20;
    localparam logic [ADDR_W-1:0] IDX_INT_STAT   = 8'h21;
    localparam logic [ADDR_W-1:0] IDX_INT_MASK   = 8'h22;
    localparam logic [ADDR_W-1:0] IDX_FLOW_CTRL  = 8'h23;

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int unsigned TAG_W       = 16;
    localparam logic [31:0] REG_RESET   = 32'h0000_0000;
    localparam logic [TAG_W-1:0] TAG_RESET = 16'h0000;
    localparam int unsigned FILT_WORDS  = 8;
    localparam int unsigned FILT_PTR_W  = 3;
    localparam logic [FILT_PTR_W-1:0] FILT_PTR_LAST = 3'h7;
    localparam int unsigned BUSY_BIT    = 0;
    localparam int unsigned TXEN_BIT    = 1;
    localparam int unsigned NUM_EVT     = 3;
    localparam int unsigned EVT_BUSY_DONE = 0;
    localparam int unsigned EVT_TAG_HIT   = 1;
    localparam int unsigned EVT_TOO_LONG  = 2;

    // Frame lengths and tag byte positions, in bytes
    localparam logic [10:0] LEN_MAX_PLAIN  = 11'h5EE;
    localparam logic [10:0] LEN_MAX_TAGGED = 11'h5F2;
    localparam logic [10:0] TAG_BYTE_HI    = 11'h00C;
    localparam logic [10:0] TAG_BYTE_LO    = 11'h00D;
    localparam logic [10:0] LEN_ONE        = 11'h001;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
    } reg_req_s;

    typedef struct packed {
        logic       valid;
        logic       first;
        logic       last;
        logic [7:0] data;
    } rx_byte_s;

    typedef enum logic [1:0] {TX_IDLE, TX_PAUSE, TX_BACKP} flow_tx_e;

endpackage

`default_nettype wire

// file: mac_flow_tag_wake.sv
// Flow-busy tracking, tag detection, frame-length limit, wake filter load.
// Assumes tx engine flags are on the same clock as the register port.
`timescale 1ns/100ps
`default_nettype none

module mac_flow_tag_wake
    import mac_flow_tag_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire reg_req_s            req,
    output logic [31:0]              rdata,
    input  wire logic                pause_req,
    input  wire logic                backp_req,
    input  wire logic                pause_done,
    input  wire logic                backp_done,
    output logic                     pause_tx_go,
    output logic                     backp_tx_go,
    input  wire rx_byte_s            rx,
    output logic                     rx_tagged,
    output logic                     rx_too_long,
    output logic [FILT_WORDS*32-1:0] wake_filter_word,
    output logic                     irq
);

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    wire hit_first  = req.addr == IDX_FIRST_TAG;
    wire hit_second = req.addr == IDX_SECOND_TAG;
    wire hit_wake   = req.addr == IDX_WAKE_LOAD;
    wire hit_flow   = req.addr == IDX_FLOW_STAT;
    wire hit_istat  = req.addr == IDX_INT_STAT;
    wire hit_imask  = req.addr == IDX_INT_MASK;
    wire hit_ctrl   = req.addr == IDX_FLOW_CTRL;
    wire wr_wake    = req.wr && hit_wake;

    logic [TAG_W-1:0]      first_tag_value_ff;
    logic [TAG_W-1:0]      second_tag_value_ff;
    logic                  tx_enable_ff;
    logic                  pause_busy_flag_ff;
    flow_tx_e              tx_state_ff;
    flow_tx_e              nxt_tx_state;
    logic [FILT_PTR_W-1:0] filt_ptr_ff;
    logic [31:0]           filt_mem_ff [FILT_WORDS];
    logic [NUM_EVT-1:0]    int_stat_ff;
    logic [NUM_EVT-1:0]    int_mask_ff;
    logic [NUM_EVT-1:0]    evt;
    logic [31:0]           nxt_rdata;

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            first_tag_value_ff  <= TAG_RESET;
            second_tag_value_ff <= TAG_RESET;
            tx_enable_ff        <= 1'b0;
            int_mask_ff         <= '0;
        end else if (req.wr) begin
            if (hit_first)
                first_tag_value_ff <= req.wdata[TAG_W-1:0];
            if (hit_second)
                second_tag_value_ff <= req.wdata[TAG_W-1:0];
            if (hit_ctrl)
                tx_enable_ff <= req.wdata[TXEN_BIT];
            if (hit_imask)
                int_mask_ff <= req.wdata[NUM_EVT-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Flow-control transmit tracking
    // ------------------------------------------------------------------
    always_comb begin
        // Pause request wins over back pressure
        nxt_tx_state = tx_state_ff;
        case (tx_state_ff)
            TX_IDLE: begin
                if (tx_enable_ff && pause_req)
                    nxt_tx_state = TX_PAUSE;
                else if (tx_enable_ff && backp_req)
                    nxt_tx_state = TX_BACKP;
            end
            TX_PAUSE: begin
                if (pause_done)
                    nxt_tx_state = TX_IDLE;
            end
            // Back pressure also stops when transmitter is disabled
            TX_BACKP: begin
                if (backp_done || !tx_enable_ff)
                    nxt_tx_state = TX_IDLE;
            end
            default: nxt_tx_state = TX_IDLE;
        endcase
    end

    assign pause_tx_go = tx_state_ff == TX_PAUSE;
    assign backp_tx_go = tx_state_ff == TX_BACKP;

    // Busy follows the next state, so it rises with the go level
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_ff        <= TX_IDLE;
            pause_busy_flag_ff <= 1'b0;
        end else begin
            tx_state_ff        <= nxt_tx_state;
            pause_busy_flag_ff <= nxt_tx_state != TX_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // Receive tag detection and length limit
    // ------------------------------------------------------------------
    logic [10:0]      rx_cnt_ff;
    logic [7:0]       tag_hi_ff;
    logic             tagged_ff;
    logic             too_long_ff;
    // Held high byte joined with the current low byte
    wire  [TAG_W-1:0] tag_field = {tag_hi_ff, rx.data};
    // Byte position, restarted by the first byte of a frame
    wire  [10:0]      rx_pos    = rx.first ? '0 : rx_cnt_ff;
    // Tag value zero matches a zero field; there is no enable bit
    wire  tag_at   = rx.valid && rx_pos == TAG_BYTE_LO;
    wire  hit1     = tag_at && tag_field == first_tag_value_ff;
    wire  hit2     = tag_at && tag_field == second_tag_value_ff;
    wire  is_tag   = tagged_ff || hit1 || hit2;
    wire  [10:0] len_max = is_tag ? LEN_MAX_TAGGED : LEN_MAX_PLAIN;
    wire  over     = rx.valid && rx_pos >= len_max;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_cnt_ff   <= '0;
            tag_hi_ff   <= '0;
            tagged_ff   <= 1'b0;
            too_long_ff <= 1'b0;
        end else if (rx.valid) begin
            // Count saturates so a runaway frame cannot wrap
            rx_cnt_ff   <= rx.last ? '0 : ((rx_pos == '1) ? rx_pos : rx_pos + LEN_ONE);
            if (rx_pos == TAG_BYTE_HI)
                tag_hi_ff <= rx.data;
            tagged_ff   <= rx.first ? (hit1 || hit2) : is_tag;
            too_long_ff <= rx.first ? over : (too_long_ff || over);
        end
    end

    assign rx_tagged   = tagged_ff;
    assign rx_too_long = too_long_ff;

    // ------------------------------------------------------------------
    // Wake-up filter load port
    // ------------------------------------------------------------------
    // Pointer steps on writes only; reads never move it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            filt_ptr_ff <= '0;
        else if (wr_wake)
            filt_ptr_ff <= (filt_ptr_ff == FILT_PTR_LAST) ? '0 : filt_ptr_ff + 1'b1;
    end

    genvar gi;
    generate
        for (gi = 0; gi < FILT_WORDS; gi++) begin : g_filt
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n)
                    filt_mem_ff[gi] <= REG_RESET;
                else if (wr_wake && filt_ptr_ff == FILT_PTR_W'(gi))
                    filt_mem_ff[gi] <= req.wdata;
            end
            assign wake_filter_word[gi*32 +: 32] = filt_mem_ff[gi];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------
    // Sticky bits; a new event wins over a clear in the same cycle
    assign evt[EVT_BUSY_DONE] = pause_busy_flag_ff && !(nxt_tx_state != TX_IDLE);
    assign evt[EVT_TAG_HIT]   = hit1 || hit2;
    assign evt[EVT_TOO_LONG]  = over && !too_long_ff;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            int_stat_ff <= '0;
        else
            int_stat_ff <= evt | (int_stat_ff & ~((req.wr && hit_istat) ? req.wdata[NUM_EVT-1:0] : '0));
    end

    // Level interrupt from unmasked sticky bits
    assign irq = |(int_stat_ff & int_mask_ff);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb begin
        // Unmapped and write-only locations read as zero
        nxt_rdata = REG_RESET;
        if (req.rd) begin
            if (hit_first)  nxt_rdata[TAG_W-1:0]   = first_tag_value_ff;
            if (hit_second) nxt_rdata[TAG_W-1:0]   = second_tag_value_ff;
            if (hit_flow)   nxt_rdata[BUSY_BIT]    = pause_busy_flag_ff;
            if (hit_ctrl)   nxt_rdata[TXEN_BIT]    = tx_enable_ff;
            if (hit_istat)  nxt_rdata[NUM_EVT-1:0] = int_stat_ff;
            if (hit_imask)  nxt_rdata[NUM_EVT-1:0] = int_mask_ff;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            rdata <= REG_RESET;
        else
            rdata <= nxt_rdata;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Flow control
    a_busy_while_pause: assert property (pause_tx_go |-> pause_busy_flag_ff)
        else $error("busy low during pause");
    a_busy_clears_done: assert property (pause_tx_go && pause_done |=> !pause_busy_flag_ff)
        else $error("busy not cleared");
    a_no_tx_disabled: assert property (!tx_enable_ff && !pause_busy_flag_ff |=> !backp_tx_go && !pause_tx_go)
        else $error("flow started while disabled");
    a_busy_while_backp: assert property (backp_tx_go |-> pause_busy_flag_ff)
        else $error("busy low during back pressure");
    a_backp_ends_done: assert property (backp_tx_go && backp_done |=> !pause_busy_flag_ff)
        else $error("busy not cleared after back pressure");
    a_busy_read_back: assert property (req.rd && hit_flow |=> rdata[BUSY_BIT] == $past(pause_busy_flag_ff))
        else $error("busy read back wrong");
    a_pause_start: assert property (tx_enable_ff && !pause_busy_flag_ff && pause_req |=> pause_tx_go)
        else $error("pause not started");
    a_stat_busy_set: assert property (evt[EVT_BUSY_DONE] |=> int_stat_ff[EVT_BUSY_DONE])
        else $error("busy end not recorded");

    // Receive path
    wire at_plain_max = rx.valid && rx_pos == LEN_MAX_PLAIN;
    wire at_tag_max   = rx.valid && rx_pos == LEN_MAX_TAGGED;
    a_tag_first_hit: assert property (hit1 && rx.valid |=> rx_tagged)
        else $error("first tag not flagged");
    a_tag_second_hit: assert property (hit2 && rx.valid |=> rx_tagged)
        else $error("second tag not flagged");
    a_len_limit_plain: assert property (rx.valid && !is_tag && rx_pos == LEN_MAX_PLAIN |=> rx_too_long)
        else $error("long frame missed");
    a_len_limit_tagged: assert property (at_tag_max && is_tag |=> rx_too_long)
        else $error("long tagged frame missed");
    a_tag_len_ok: assert property (at_plain_max && rx_tagged && !rx_too_long |=> !rx_too_long)
        else $error("tagged frame cut short");
    a_tagged_holds: assert property (rx_tagged && !(rx.valid && rx.first) |=> rx_tagged)
        else $error("tagged flag dropped");
    a_too_long_holds: assert property (rx_too_long && !(rx.valid && rx.first) |=> rx_too_long)
        else $error("too long flag dropped");
    a_tag_hi_capture: assert property (rx.valid && rx_pos == TAG_BYTE_HI |=> tag_hi_ff == $past(rx.data))
        else $error("tag high byte not held");
    a_tag_miss_clear: assert property (rx.valid && rx.first |=> !rx_tagged)
        else $error("tagged flag not restarted");
    a_tag1_load: assert property (req.wr && hit_first |=> first_tag_value_ff == $past(req.wdata[TAG_W-1:0]))
        else $error("first tag not loaded");
    a_tag2_load: assert property (req.wr && hit_second |=> second_tag_value_ff == $past(req.wdata[TAG_W-1:0]))
        else $error("second tag not loaded");

    // Filter port
    a_filt_ptr_step: assert property (wr_wake |=> filt_ptr_ff == FILT_PTR_W'($past(filt_ptr_ff) + 1'b1))
        else $error("pointer did not step");
    a_filt_ptr_wrap: assert property (wr_wake && filt_ptr_ff == FILT_PTR_LAST |=> filt_ptr_ff == '0)
        else $error("pointer did not wrap");
    a_filt_load_word: assert property (wr_wake |=> filt_mem_ff[$past(filt_ptr_ff)] == $past(req.wdata))
        else $error("filter word not loaded");
    a_wake_read_zero: assert property (req.rd && hit_wake |=> rdata == REG_RESET && $stable(filt_ptr_ff))
        else $error("filter port read wrong");
    a_ptr_hold_idle: assert property (!wr_wake |=> $stable(filt_ptr_ff))
        else $error("pointer moved without write");
    a_filt_word_hold: assert property (!wr_wake |=> $stable(wake_filter_word))
        else $error("filter changed without write");

    // ------------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------------
    c_pause_frame: cover property (pause_tx_go ##[1:20] !pause_busy_flag_ff);
    c_backp_seq:   cover property (backp_tx_go);
    c_tag_frame:   cover property (hit1);
    c_filt_wrap:   cover property (wr_wake && filt_ptr_ff == FILT_PTR_LAST);
    c_filt_read:   cover property (req.rd && hit_wake);

endmodule

`default_nettype wire

// file: testbench.sv
// Self-checking bench for the flow-busy, tag and wake-filter slice.
// Assumes link_partner answers the transmit sequences.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import mac_flow_tag_pkg::*;
    logic clock, rst_n, pause_req, backp_req, slow, pause_done, backp_done;
    logic pause_tx_go, backp_tx_go, rx_tagged, rx_too_long, irq;
    logic [31:0] rdata, d;
    logic [FILT_WORDS*32-1:0] wake_filter_word;
    reg_req_s req;
    rx_byte_s rx;
    logic [31:0] fw[8];
    logic [15:0] tag1, tag2;
    int failures, n_tests, seed, ptr, k;
    mac_flow_tag_wake mac_flow_tag_wake_i (.clock(clock), .rst_n(rst_n), .req(req), .rdata(rdata),
        .pause_req(pause_req), .backp_req(backp_req), .pause_done(pause_done), .backp_done(backp_done),
        .pause_tx_go(pause_tx_go), .backp_tx_go(backp_tx_go), .rx(rx), .rx_tagged(rx_tagged),
        .rx_too_long(rx_too_long), .wake_filter_word(wake_filter_word), .irq(irq));
    link_partner link_partner_i (.clock(clock), .rst_n(rst_n), .pause_tx_go(pause_tx_go),
        .backp_tx_go(backp_tx_go), .slow(slow), .pause_done(pause_done), .backp_done(backp_done));
    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task chk32(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task test_done;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        req <= '{1'b1, 1'b0, a, v};
        @(posedge clock);
        req <= '0;
        #1;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        req <= '{1'b0, 1'b1, a, 32'h0000_0000};
        @(posedge clock);
        req <= '0;
        #1 v = rdata;
    endtask
    task tick_wait(input logic want);
        int n;
        n = 0;
        while (((pause_tx_go | backp_tx_go) !== want) && n < 100) begin
            @(posedge clock) #1;
            n++;
        end
    endtask
    task flow(input int kind, input logic sl, input logic msk);
        wr(IDX_INT_MASK, {31'h0, msk});
        rd(IDX_INT_MASK, d);
        chk32(d, {31'h0, msk});
        @(posedge clock);
        slow <= sl;
        if (kind == 0) pause_req <= 1'b1;
        else backp_req <= 1'b1;
        tick_wait(1'b1);
        chk1(kind == 0 ? pause_tx_go : backp_tx_go, 1'b1);
        @(posedge clock);
        pause_req <= 1'b0;
        backp_req <= 1'b0;
        if (sl) begin
            rd(IDX_FLOW_STAT, d);
            chk32(d, 32'h0000_0001);
        end
        tick_wait(1'b0);
        rd(IDX_FLOW_STAT, d);
        chk32(d, 32'h0000_0000);
        rd(IDX_INT_STAT, d);
        chk32(d & 32'h1, 32'h0000_0001);
        chk1(irq, msk);
        wr(IDX_INT_STAT, 32'h0000_0001);
        chk1(irq, 1'b0);
    endtask
    task frame(input int len, input logic [7:0] hi, input logic [7:0] lo);
        logic tg;
        int i;
        for (i = 1; i <= len; i++) begin
            @(posedge clock);
            rx <= '{1'b1, i == 1, i == len, (i == 13) ? hi : (i == 14) ? lo : 8'($random(seed))};
        end
        @(posedge clock);
        rx <= '0;
        #1;
        tg = ({hi, lo} == tag1) || ({hi, lo} == tag2);
        chk1(rx_tagged, tg);
        chk1(rx_too_long, len > (tg ? 1522 : 1518));
        rd(IDX_INT_STAT, d);
        chk32(d & 32'h0000_0006, {29'h0, len > (tg ? 1522 : 1518), tg, 1'b0});
        wr(IDX_INT_STAT, 32'h0000_0006);
    endtask
    // ------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        #300000;
        failures++;
        test_done;
    end
    initial begin
        {rst_n, pause_req, backp_req, slow} = 4'h0;
        req = '0;
        rx = '0;
        seed = 89511;
        ptr = 0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        rd(IDX_FIRST_TAG, d);
        chk32(d, REG_RESET);
        rd(IDX_SECOND_TAG, d);
        chk32(d, REG_RESET);
        rd(8'h30, d);
        chk32(d, 32'h0000_0000);
        tag1 = 16'h8100;
        tag2 = 16'($random(seed));
        wr(IDX_FIRST_TAG, {16'($random(seed)), tag1});
        wr(IDX_SECOND_TAG, {16'($random(seed)), tag2});
        rd(IDX_FIRST_TAG, d);
        chk32(d, {16'h0, tag1});
        rd(IDX_SECOND_TAG, d);
        chk32(d, {16'h0, tag2});
        for (k = 0; k < 10; k++) begin
            d = $random(seed);
            wr(IDX_WAKE_LOAD, d);
            fw[ptr] = d;
            chk32(wake_filter_word[ptr*32+:32], d);
            ptr = (ptr + 1) % 8;
            if (k == 4) rd(IDX_WAKE_LOAD, d);
            if (k == 4) chk32(d, 32'h0000_0000);
        end
        for (k = 0; k < 8; k++) chk32(wake_filter_word[k*32+:32], fw[k]);
        @(posedge clock);
        {pause_req, backp_req} <= 2'h3;
        repeat (10) @(posedge clock);
        {pause_req, backp_req} <= 2'h0;
        #1;
        chk1(pause_tx_go | backp_tx_go, 1'b0);
        rd(IDX_FLOW_STAT, d);
        chk32(d, 32'h0000_0000);
        wr(IDX_FLOW_CTRL, 32'h0000_0002);
        rd(IDX_FLOW_CTRL, d);
        chk32(d, 32'h0000_0002);
        flow(0, 1'b1, 1'b1);
        flow(1, 1'b1, 1'b1);
        flow(0, 1'b0, 1'b0);
        flow(1, 1'b0, 1'b1);
        frame(1518, 8'h08, 8'h00);
        frame(1519, 8'h08, 8'h00);
        frame(1522, 8'h81, 8'h00);
        frame(1523, 8'h81, 8'h00);
        frame(1522, tag2[15:8], tag2[7:0]);
        frame(20, 8'h81, 8'h00);
        test_done;
    end
endmodule
`default_nettype wire
